//--- dv/pin_source.sv
// Partner: drives the external counter pin level.
// Assumes the bench calls drive() just after a clock edge.
module pin_source (
  // Pin level
  output logic pin_o
);
  timeunit 1ns;
  timeprecision 1ns;
  initial pin_o = 1'b0;
  // Hold a level for the given number of nanoseconds
  task automatic drive(input logic lvl, input int ns);
    pin_o = lvl;
    #(ns);
  endtask : drive
endmodule : pin_source

//--- dv/tb_realtime_counter_watchdog.sv
// Bench: scenario tasks for the counter, prescaler and watchdog.
// Assumes a 4 ns clock and a watchdog tick shortened to 4 cycles.
module tb_realtime_counter_watchdog;
  timeunit 1ns;
  timeprecision 1ns;
  import rtc_wdog_pkg::*;
  logic       clk = 1'b0, rstn = 1'b0, instr = 1'b0, wr = 1'b0;
  logic       pclr = 1'b0, wclr = 1'b0, pin, irq, pend, wto;
  logic [7:0] opt = 8'h08, wdata = 8'h00, cnt;
  int         miscompares = 0, samples_checked = 0, cycles = 0;
  always #2 clk = ~clk;
  pin_source pin_source_inst (.pin_o(pin));
  realtime_counter_watchdog #(.WDT_TICK(4)) realtime_counter_watchdog_inst (
    .CLK_SYS_I(clk), .RSTN_I(rstn), .INSTR_CYC_I(instr), .OPTION_I(opt),
    .CNT_PIN_I(pin), .CNT_WR_I(wr), .CNT_WDATA_I(wdata),
    .PEND_CLR_I(pclr), .WDT_CLR_I(wclr), .CNT_VALUE_O(cnt),
    .ROLL_IRQ_O(irq), .ROLL_PEND_O(pend), .WDT_TIMEOUT_O(wto));
  // ----------------------------------------------------------------
  // Shared helpers
  // ----------------------------------------------------------------
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : cyc
  task automatic chk(input bit ok, input string m);
    samples_checked++;
    if (!ok) begin
      miscompares++;
      $display("[ERR] %0t %s", $time, m);
    end
  endtask : chk
  task automatic load(input logic [7:0] d);
    wr = 1'b1;
    wdata = d;
    cyc(1);
    wr = 1'b0;
  endtask : load
  task automatic run(input int n);
    instr = 1'b1;
    cyc(n);
    instr = 1'b0;
  endtask : run
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : give_verdict
  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_base();
    chk(cnt === CNT_RST && pend === 1'b0, "reset values");
    chk(irq === 1'b0 && wto === 1'b0, "reset pulses");
    opt = 8'h08;
    load(8'h00);
    run(5);
    chk(cnt === 8'h05, "internal count");
    $display("test base done");
  endtask : t_base
  task automatic t_roll();
    int hits = 0;
    opt = 8'h08;
    load(8'hfe);
    run(2);
    repeat (3) begin
      hits += int'(irq === 1'b1);
      cyc(1);
    end
    chk(hits == 1 && cnt === 8'h00, "rollover pulse");
    chk(pend === 1'b1, "pending not set");
    instr = 1'b1;
    load(8'hff);
    instr = 1'b0;
    chk(cnt === 8'hff, "write lost to increment");
    pclr = 1'b1;
    cyc(1);
    pclr = 1'b0;
    cyc(1);
    chk(pend === 1'b0, "pending not cleared");
    // Rollover and clear in one cycle: the set wins
    instr = 1'b1;
    pclr = 1'b1;
    cyc(1);
    instr = 1'b0;
    pclr = 1'b0;
    chk(pend === 1'b1 && cnt === 8'h00, "set lost to clear");
    $display("test rollover done");
  endtask : t_roll
  task automatic t_pre();
    for (int r = 0; r < 8; r++) begin
      cyc(1);
      opt = 8'(r);
      run(3);
      load(8'h00);
      run((2 << r) - 1);
      chk(cnt === 8'h00, "prescaler not cleared");
      cyc(1);
      run(1);
      chk(cnt === 8'h01, "prescaled count");
    end
    $display("test prescaler done");
  endtask : t_pre
  task automatic t_ext();
    opt = 8'h28;
    load(8'h00);
    pin_source_inst.drive(1'b1, 16);
    cyc(2);
    chk(cnt === 8'h01, "rising edge");
    pin_source_inst.drive(1'b0, 16);
    cyc(2);
    chk(cnt === 8'h01, "falling counted");
    opt = 8'h38;
    pin_source_inst.drive(1'b1, 16);
    cyc(2);
    chk(cnt === 8'h01, "rising counted");
    pin_source_inst.drive(1'b0, 16);
    cyc(2);
    chk(cnt === 8'h02, "falling edge");
    $display("test external done");
  endtask : t_ext
  task automatic t_wdog(input logic prescaler_assign_bit, input int exp);
    int n = 0;
    int d;
    opt = {4'h0, prescaler_assign_bit, 3'h0};
    wclr = 1'b1;
    cyc(1);
    wclr = 1'b0;
    while (wto !== 1'b1 && n < 3000) begin
      cyc(1);
      n++;
    end
    d = n - exp;
    chk(d >= -12 && d <= 12, "watchdog period");
    $display("test watchdog done");
  endtask : t_wdog
  // Cut a hang short
  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      miscompares++;
      give_verdict();
    end
  end
  // Main sequence
  initial begin
    cyc(2);
    rstn = 1'b1;
    t_base();
    t_roll();
    t_pre();
    t_ext();
    t_wdog(1'b0, 1024);
    t_wdog(1'b1, 2048);
    give_verdict();
  end
endmodule : tb_realtime_counter_watchdog

//--- src/realtime_counter_watchdog.sv
// Real-time counter with shared prescaler and watchdog timer.
// Assumes inputs other than CNT_PIN_I are synchronous to CLK_SYS_I; option bits are plain ports.
//
// Overview of operation
// [R1] 8-bit counter advances per instruction cycle or per external edge.
// [R2] Option bit 5 clear selects instruction clock, set selects pin.
// [R3] Option bit 4 set counts falling edges, clear counts rising edges.
// [R4] 8-bit prescaler ahead of counter extends chain to 16 bits.
// [R5] Internal mode: every cycle, or only on prescaler output if assigned.
// [R6] Rollover FFh to 00h raises interrupt and sets pending flag bit 7.
// [R7] Counter write clears prescaler only while assignment bit is 0.
// [R8] 8-bit watchdog shares the same prescaler.
// [R9] Unassigned to counter, prescaler acts as watchdog postscaler.
// [R10] Option bit 3 set gives prescaler to watchdog, clear to counter.
// [R11] Three rate bits select division ratio for the assigned user.
// [R12] Prescaler count is invisible to software except clear and rate.
// [R13] External pin is synchronised and edge detected; one count per edge.
// [R14] Watchdog terminal count asserts a timeout toward reset logic.
module realtime_counter_watchdog #(
  parameter int WDT_TICK = rtc_wdog_pkg::WDT_TICK_CYCLES
) (
  // Clock and reset
  input  wire logic                         CLK_SYS_I,
  input  wire logic                         RSTN_I,
  // Instruction-cycle enable
  input  wire logic                         INSTR_CYC_I,
  // Option register bits
  input  wire logic [rtc_wdog_pkg::OPT_W-1:0] OPTION_I,
  // External counter pin
  input  wire logic                         CNT_PIN_I,
  // Software write to counter
  input  wire logic                         CNT_WR_I,
  input  wire logic [rtc_wdog_pkg::CNT_W-1:0] CNT_WDATA_I,
  // Pending flag clear and watchdog clear
  input  wire logic                         PEND_CLR_I,
  input  wire logic                         WDT_CLR_I,
  // Status outputs
  output logic      [rtc_wdog_pkg::CNT_W-1:0] CNT_VALUE_O,
  output logic                              ROLL_IRQ_O,
  output logic                              ROLL_PEND_O,
  output logic                              WDT_TIMEOUT_O
);
  import rtc_wdog_pkg::*;

  // ----------------------------------------------------------------
  // Option decode
  // ----------------------------------------------------------------
  wire       ext_src   = OPTION_I[SRC_SEL_BIT];            // see [R2]
  wire       fall_edge = OPTION_I[EDGE_SEL_BIT];           // see [R3]
  wire       psa_wdt   = OPTION_I[PSA_BIT];                // see [R10]
  wire [2:0] rate      = OPTION_I[RATE_LSB +: RATE_W];     // see [R11]

  // ----------------------------------------------------------------
  // Pin synchroniser and edge detect
  // ----------------------------------------------------------------
  logic pin_meta_ff, pin_sync_ff, pin_prev_ff;
  // Two flops to settle the pin, a third for edge detect
  always_ff @(posedge CLK_SYS_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      pin_meta_ff <= 1'b0;
      pin_sync_ff <= 1'b0;
      pin_prev_ff <= 1'b0;
    end else begin
      pin_meta_ff <= CNT_PIN_I;
      pin_sync_ff <= pin_meta_ff;
      pin_prev_ff <= pin_sync_ff;
    end
  end
  wire pin_rise = pin_sync_ff & ~pin_prev_ff;
  wire pin_fall = ~pin_sync_ff & pin_prev_ff;
  wire pin_evt  = fall_edge ? pin_fall : pin_rise;        // see [R13]

  // ----------------------------------------------------------------
  // Watchdog base tick divider
  // ----------------------------------------------------------------
  logic [15:0] tick_cnt_ff;
  wire         wdt_tick = (tick_cnt_ff == 16'(WDT_TICK - 1));
  // Base tick count, restarted by a watchdog clear
  always_ff @(posedge CLK_SYS_I or negedge RSTN_I) begin
    if (!RSTN_I)
      tick_cnt_ff <= 16'h0000;
    else if (wdt_tick || WDT_CLR_I)
      tick_cnt_ff <= 16'h0000;
    else
      tick_cnt_ff <= tick_cnt_ff + 16'h0001;
  end

  // ----------------------------------------------------------------
  // Shared prescaler input and output select
  // ----------------------------------------------------------------
  wire       cnt_src_evt = ext_src ? pin_evt : INSTR_CYC_I;  // see [R1]
  logic [PRE_W-1:0] pre_ff;  // No software read or write path; see [R12]
  logic [7:0]       wdt_ff;
  wire       wdt_wrap = wdt_tick && (wdt_ff == CNT_MAX);
  // Prescaler clocked by counter source or by watchdog wrap
  wire       pre_in   = psa_wdt ? wdt_wrap : cnt_src_evt;    // see [R9]
  wire [PRE_W-1:0] pre_mask = PRE_W'((9'h002 << rate) - 9'h001);
  wire       pre_out  = pre_in && ((pre_ff & pre_mask) == pre_mask);
  // Clear when counter written under counter ownership
  wire       pre_clr  = (CNT_WR_I && !psa_wdt) ||
                        (WDT_CLR_I && psa_wdt);               // see [R7]
  // Prescaler count: clear first, then one step per input
  always_ff @(posedge CLK_SYS_I or negedge RSTN_I) begin
    if (!RSTN_I)
      pre_ff <= PRE_RST;
    else if (pre_clr)
      pre_ff <= PRE_RST;                                     // see [R7]
    else if (pre_in)
      pre_ff <= pre_ff + 8'h01;                              // see [R4]
  end

  // ----------------------------------------------------------------
  // Real-time counter and rollover flag
  // ----------------------------------------------------------------
  wire cnt_inc = psa_wdt ? cnt_src_evt : pre_out;           // see [R5]
  wire roll    = cnt_inc && !CNT_WR_I && (CNT_VALUE_O == CNT_MAX);
  // Counter: software write wins over increment
  always_ff @(posedge CLK_SYS_I or negedge RSTN_I) begin
    if (!RSTN_I)
      CNT_VALUE_O <= CNT_RST;
    else if (CNT_WR_I)
      CNT_VALUE_O <= CNT_WDATA_I;
    else if (cnt_inc)
      CNT_VALUE_O <= CNT_VALUE_O + 8'h01;                    // see [R1]
  end
  // Pending flag: set wins over clear
  always_ff @(posedge CLK_SYS_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      ROLL_PEND_O <= 1'b0;
      ROLL_IRQ_O  <= 1'b0;
    end else begin
      ROLL_IRQ_O  <= roll;                                   // see [R6]
      if (roll)
        ROLL_PEND_O <= 1'b1;                                 // see [R6]
      else if (PEND_CLR_I)
        ROLL_PEND_O <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Watchdog counter and timeout
  // ----------------------------------------------------------------
  wire wdt_term = psa_wdt ? pre_out : wdt_wrap;             // see [R14]
  // Watchdog count, one step per base tick
  always_ff @(posedge CLK_SYS_I or negedge RSTN_I) begin
    if (!RSTN_I)
      wdt_ff <= WDT_RST;
    else if (WDT_CLR_I)
      wdt_ff <= WDT_RST;
    else if (wdt_tick)
      wdt_ff <= wdt_ff + 8'h01;                              // see [R8]
  end
  // Timeout pulse, suppressed by a clear in the same cycle
  always_ff @(posedge CLK_SYS_I or negedge RSTN_I) begin
    if (!RSTN_I)
      WDT_TIMEOUT_O <= 1'b0;
    else
      WDT_TIMEOUT_O <= wdt_term && !WDT_CLR_I;               // see [R14]
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge CLK_SYS_I); endclocking
  default disable iff (!RSTN_I);

  // Rollover: pulse, sticky flag, wrap to zero
  a_roll_sets_pend: assert property (                   // see [R6]
    roll |=> ROLL_PEND_O && ROLL_IRQ_O)
    else $error("rollover did not set pending flag");
  a_roll_value_zero: assert property (                  // see [R6]
    roll |=> CNT_VALUE_O == 8'h00)
    else $error("rollover did not wrap to zero");
  a_pend_holds: assert property (                       // see [R6]
    ROLL_PEND_O && !PEND_CLR_I |=> ROLL_PEND_O)
    else $error("pending flag dropped without clear");

  // Count source and edge selection
  a_int_nopre_inc: assert property (                    // see [R5]
    INSTR_CYC_I && !ext_src && psa_wdt && !CNT_WR_I
    |=> CNT_VALUE_O == $past(CNT_VALUE_O) + 8'h01)
    else $error("counter missed instruction cycle");
  a_ext_no_instr: assert property (                     // see [R2]
    ext_src && !pin_evt && !CNT_WR_I
    |=> CNT_VALUE_O == $past(CNT_VALUE_O))
    else $error("external mode counted without edge");
  a_edge_select: assert property (                      // see [R3]
    ext_src && psa_wdt && !CNT_WR_I && fall_edge && pin_rise
    |=> CNT_VALUE_O == $past(CNT_VALUE_O))
    else $error("wrong edge counted");
  a_pin_one_count: assert property (                    // see [R13]
    pin_evt |=> !pin_evt)
    else $error("edge counted twice");

  // Software write and prescaler ownership
  a_write_loads: assert property (                      // see [R1]
    CNT_WR_I |=> CNT_VALUE_O == $past(CNT_WDATA_I))
    else $error("counter write not loaded");
  a_write_clears_pre: assert property (                 // see [R7]
    CNT_WR_I && !psa_wdt |=> pre_ff == PRE_RST)
    else $error("counter write left prescaler");
  a_pre_kept_wdt: assert property (                     // see [R7]
    CNT_WR_I && psa_wdt && !WDT_CLR_I && !pre_in
    |=> pre_ff == $past(pre_ff))
    else $error("counter write cleared watchdog prescaler");
  a_pre_gates_cnt: assert property (                    // see [R4]
    !psa_wdt && !pre_out && !CNT_WR_I
    |=> CNT_VALUE_O == $past(CNT_VALUE_O))
    else $error("counter advanced without prescaler output");

  // Watchdog timeout pulse
  a_wdt_timeout: assert property (                      // see [R14]
    wdt_term && !WDT_CLR_I |=> WDT_TIMEOUT_O)
    else $error("watchdog timeout missing");
  a_wdt_clr_quiet: assert property (                    // see [R14]
    WDT_CLR_I |=> !WDT_TIMEOUT_O)
    else $error("watchdog timeout despite clear");

  // Main scenarios reached
  c_rollover:      cover property (roll);
  c_pend_set_wins: cover property (roll && PEND_CLR_I);
  c_ext_fall:      cover property (ext_src && fall_edge && pin_evt);
  c_pre_output:    cover property (!psa_wdt && pre_out && rate == 3'h7);
  c_wdt_expire:    cover property (WDT_TIMEOUT_O);

endmodule : realtime_counter_watchdog

//--- src/rtc_wdog_pkg.sv
// Package: constants for the real-time counter and watchdog block
// Assumes a single 250 MHz system clock and instruction-cycle enable.
package rtc_wdog_pkg;

  // ----------------------------------------------------------------
  // Option register field positions
  // ----------------------------------------------------------------
  localparam int OPT_W        = 8;
  localparam int SRC_SEL_BIT  = 5;  // External source select
  localparam int EDGE_SEL_BIT = 4;  // Falling edge select
  localparam int PSA_BIT      = 3;  // prescaler_assign_bit
  localparam int RATE_LSB     = 0;  // prescale_rate_bit0..2
  localparam int RATE_W       = 3;

  // ----------------------------------------------------------------
  // Widths and reset values
  // ----------------------------------------------------------------
  localparam int CNT_W                 = 8;
  localparam int PRE_W                 = 8;
  localparam logic [7:0] CNT_RST       = 8'h00;
  localparam logic [7:0] PRE_RST       = 8'h00;
  localparam logic [7:0] WDT_RST       = 8'h00;
  localparam logic [7:0] CNT_MAX       = 8'hff;
  localparam logic [7:0] OPTION_RST    = 8'hff;
  localparam logic [7:0] WDT_BASE_RST  = 8'h00;

  // ----------------------------------------------------------------
  // Watchdog base tick period
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS   = 4;
  localparam int WDT_TICK_NS     = 1024;
  localparam int WDT_TICK_CYCLES = WDT_TICK_NS / CLK_PERIOD_NS;

endpackage : rtc_wdog_pkg
